//--- verilog/ioc_top.sv
// module: io configuration and operating state control of the reader front end
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps

// Functional notes
// - bit 6 set turns digital regulator off
// - tuning dac runs when bit5 and ready
// - bit5 without ready holds tuning fixed
// - bit4: spi pulldown when selected, undriven
// - bit3: miso pulldown while deselected
// - bit2 raises miso, clock, irq drive
// - bit1 picks am reference: driver or rf
// - control bit7 starts oscillator, ready mode
// - control bit6 enables receiver
// - bit5 chooses both channels or one
// - bit4 chooses automatic or manual channel
// - tx enable set on field-on, cleared after tx done in active peer link
// - bit2 enables wake-up mode
// - field detector two-bit mode decode
// - detector alone means low-power initial mode
module ioc_top
(
	input  wire logic       I_REF_CLK,
	input  wire logic       I_RST_B,
	input  wire logic       I_CE,
	input  wire logic [7:0] I_ADDR,
	input  wire logic [7:0] I_WDATA,
	input  wire logic       I_WR,
	input  wire logic       I_RD,
	output logic      [7:0] O_RDATA,
	input  wire logic       I_FIELD_ON_CMD,
	input  wire logic       I_TX_DONE,
	input  wire logic       I_ACTIVE_PEER_LINK,
	input  wire logic       I_CHANNEL_PICK,
	input  wire logic       I_SPI_MODE,
	input  wire logic       I_CHIP_SELECT_N,
	input  wire logic       I_MISO_DRIVEN,
	output logic            O_SUPPLY_3V,
	output logic            O_DIG_REG_OFF,
	output logic            O_TUNE_DAC_RUN,
	output logic            O_TUNE_HOLD_FIXED,
	output logic            O_TUNE_FIXED_VALID,
	output logic            O_MISO_PULLDOWN,
	output logic            O_IO_DRIVE_HIGH,
	output logic            O_AM_REGULATOR_REF_SELECT,
	output logic            O_AM_ACTIVE_SINK,
	output logic            O_READY,
	output logic            O_RX_EN,
	output logic            O_RX_AM_EN,
	output logic            O_RX_PM_EN,
	output logic            O_RX_AUTO_SELECT,
	output logic            O_TX_EN,
	output logic            O_WAKEUP_MODE_ENABLE,
	output logic            O_FD_ENABLE,
	output logic            O_FD_PEER_THRESHOLD,
	output logic            O_FD_AUTO,
	output logic            O_LOW_POWER_NFC
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic supply_3v;
		logic dig_reg_off;
		logic tune_run;
		logic tune_hold;
		logic ready_seen;
		logic tune_valid;
		logic miso_pd;
		logic drive_high;
		logic am_ref;
		logic am_sink;
		logic ready;
		logic rx_en;
		logic rx_am;
		logic rx_pm;
		logic rx_auto;
		logic tx_en;
		logic wakeup;
		logic fd_en;
		logic fd_peer;
		logic fd_auto;
		logic low_power;
	} ioc_out_t;

	ioc_out_t   st_r;
	ioc_out_t   st_nxt;
	logic       cs_n_s;
	logic [7:0] io2;
	logic [7:0] opc;
	logic [1:0] fd;

	ioc_reg_if rif ();

	// ----------------------------------------------------------------
	// submodules
	// ----------------------------------------------------------------
	ioc_bank i_ioc_bank
	(
		.i_clk   (I_REF_CLK),
		.i_rst_b (I_RST_B),
		.i_ce    (I_CE),
		.i_addr  (I_ADDR),
		.i_wdata (I_WDATA),
		.i_wr    (I_WR),
		.i_rd    (I_RD),
		.o_rdata (O_RDATA),
		.rif     (rif.bank)
	);

	ioc_sync2 i_ioc_sync2
	(
		.i_clk   (I_REF_CLK),
		.i_rst_b (I_RST_B),
		.i_ce    (I_CE),
		.i_async (I_CHIP_SELECT_N),
		.o_sync  (cs_n_s)
	);

	// field-on command forces transmit on; end of an active-mode transmission drops it
	assign rif.tx_set = I_FIELD_ON_CMD;
	assign rif.tx_clr = I_TX_DONE && I_ACTIVE_PEER_LINK;

	assign io2 = rif.io_cfg2;
	assign opc = rif.op_ctl;
	assign fd  = opc[ioc_pkg::OPC_FD_HI:ioc_pkg::OPC_FD_LO];

	// ----------------------------------------------------------------
	// output decode
	// ----------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		if (I_CE)
		begin
			st_nxt.supply_3v   = io2[ioc_pkg::IO2_SUPPLY_3V];
			st_nxt.dig_reg_off = io2[ioc_pkg::IO2_DIG_REG_OFF];
			st_nxt.tune_run    = io2[ioc_pkg::IO2_TUNE_DAC_EN] && opc[ioc_pkg::OPC_READY];
			st_nxt.tune_hold   = io2[ioc_pkg::IO2_TUNE_DAC_EN] && !opc[ioc_pkg::OPC_READY];
			// fixed tuning value is meaningful only after ready has been on once
			st_nxt.ready_seen  = st_r.ready_seen || opc[ioc_pkg::OPC_READY];
			st_nxt.tune_valid  = st_nxt.tune_hold && st_r.ready_seen;
			st_nxt.miso_pd     = (io2[ioc_pkg::IO2_PD_IDLE_SEL] && !cs_n_s && I_SPI_MODE
				&& !I_MISO_DRIVEN)
				|| (io2[ioc_pkg::IO2_PD_DESEL] && cs_n_s);
			st_nxt.drive_high  = io2[ioc_pkg::IO2_DRIVE_HIGH];
			st_nxt.am_ref      = io2[ioc_pkg::IO2_AM_REF_SELECT];
			st_nxt.am_sink     = io2[ioc_pkg::IO2_AM_SINK];
			st_nxt.ready       = opc[ioc_pkg::OPC_READY];
			st_nxt.rx_en       = opc[ioc_pkg::OPC_RX_EN];
			// single channel: pick low selects am, high selects pm
			if (!opc[ioc_pkg::OPC_RX_EN])
			begin
				st_nxt.rx_am = 1'b0;
				st_nxt.rx_pm = 1'b0;
			end
			else if (opc[ioc_pkg::OPC_RX_SINGLE])
			begin
				st_nxt.rx_am = !I_CHANNEL_PICK;
				st_nxt.rx_pm = I_CHANNEL_PICK;
			end
			else
			begin
				st_nxt.rx_am = 1'b1;
				st_nxt.rx_pm = 1'b1;
			end
			st_nxt.rx_auto     = opc[ioc_pkg::OPC_RX_EN] && !opc[ioc_pkg::OPC_RX_SINGLE]
				&& !opc[ioc_pkg::OPC_RX_MANUAL];
			st_nxt.tx_en       = opc[ioc_pkg::OPC_TX_EN];
			st_nxt.wakeup      = opc[ioc_pkg::OPC_WAKEUP];
			case (fd)
				ioc_pkg::FD_OFF:
				begin
					st_nxt.fd_en   = 1'b0;
					st_nxt.fd_peer = 1'b0;
					st_nxt.fd_auto = 1'b0;
				end
				ioc_pkg::FD_MAN_COLL:
				begin
					st_nxt.fd_en   = 1'b1;
					st_nxt.fd_peer = 1'b0;
					st_nxt.fd_auto = 1'b0;
				end
				ioc_pkg::FD_MAN_PEER:
				begin
					st_nxt.fd_en   = 1'b1;
					st_nxt.fd_peer = 1'b1;
					st_nxt.fd_auto = 1'b0;
				end
				default:
				begin
					st_nxt.fd_en   = 1'b1;
					st_nxt.fd_peer = 1'b0;
					st_nxt.fd_auto = 1'b1;
				end
			endcase
			st_nxt.low_power   = ioc_pkg::ioc_low_power(opc);
		end
	end

	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_B)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign O_SUPPLY_3V               = st_r.supply_3v;
	assign O_DIG_REG_OFF             = st_r.dig_reg_off;
	assign O_TUNE_DAC_RUN            = st_r.tune_run;
	assign O_TUNE_HOLD_FIXED         = st_r.tune_hold;
	assign O_TUNE_FIXED_VALID        = st_r.tune_valid;
	assign O_MISO_PULLDOWN           = st_r.miso_pd;
	assign O_IO_DRIVE_HIGH           = st_r.drive_high;
	assign O_AM_REGULATOR_REF_SELECT = st_r.am_ref;
	assign O_AM_ACTIVE_SINK          = st_r.am_sink;
	assign O_READY                   = st_r.ready;
	assign O_RX_EN                   = st_r.rx_en;
	assign O_RX_AM_EN                = st_r.rx_am;
	assign O_RX_PM_EN                = st_r.rx_pm;
	assign O_RX_AUTO_SELECT          = st_r.rx_auto;
	assign O_TX_EN                   = st_r.tx_en;
	assign O_WAKEUP_MODE_ENABLE      = st_r.wakeup;
	assign O_FD_ENABLE               = st_r.fd_en;
	assign O_FD_PEER_THRESHOLD       = st_r.fd_peer;
	assign O_FD_AUTO                 = st_r.fd_auto;
	assign O_LOW_POWER_NFC           = st_r.low_power;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_dig_reg;
		@(posedge I_REF_CLK) disable iff (!I_RST_B)
		I_CE |=> (O_DIG_REG_OFF == $past(io2[ioc_pkg::IO2_DIG_REG_OFF]));
	endproperty
	a_dig_reg: assert property (p_dig_reg) else $error("regulator off mismatch");

	property p_tune_run;
		@(posedge I_REF_CLK) disable iff (!I_RST_B)
		(I_CE && io2[ioc_pkg::IO2_TUNE_DAC_EN] && opc[ioc_pkg::OPC_READY])
			|=> (O_TUNE_DAC_RUN && !O_TUNE_HOLD_FIXED);
	endproperty
	a_tune_run: assert property (p_tune_run) else $error("tuning dac not running");

	property p_tune_hold;
		@(posedge I_REF_CLK) disable iff (!I_RST_B)
		(I_CE && io2[ioc_pkg::IO2_TUNE_DAC_EN] && !opc[ioc_pkg::OPC_READY])
			|=> (O_TUNE_HOLD_FIXED && !O_TUNE_DAC_RUN);
	endproperty
	a_tune_hold: assert property (p_tune_hold) else $error("tuning not held");

	property p_pd_sel;
		@(posedge I_REF_CLK) disable iff (!I_RST_B)
		(I_CE && io2[ioc_pkg::IO2_PD_IDLE_SEL] && !cs_n_s && I_SPI_MODE && !I_MISO_DRIVEN)
			|=> O_MISO_PULLDOWN;
	endproperty
	a_pd_sel: assert property (p_pd_sel) else $error("selected pulldown missing");

	property p_pd_desel;
		@(posedge I_REF_CLK) disable iff (!I_RST_B)
		(I_CE && cs_n_s) |=> (O_MISO_PULLDOWN == $past(io2[ioc_pkg::IO2_PD_DESEL]));
	endproperty
	a_pd_desel: assert property (p_pd_desel) else $error("deselect pulldown wrong");

	property p_drive;
		@(posedge I_REF_CLK) disable iff (!I_RST_B)
		I_CE ##1 I_CE |=> (O_IO_DRIVE_HIGH == $past(io2[ioc_pkg::IO2_DRIVE_HIGH]));
	endproperty
	a_drive: assert property (p_drive) else $error("drive level mismatch");

	property p_am_ref;
		@(posedge I_REF_CLK) disable iff (!I_RST_B)
		I_CE |=> (O_AM_REGULATOR_REF_SELECT == $past(io2[ioc_pkg::IO2_AM_REF_SELECT]));
	endproperty
	a_am_ref: assert property (p_am_ref) else $error("am reference mismatch");

	property p_ready;
		@(posedge I_REF_CLK) disable iff (!I_RST_B)
		I_CE |=> (O_READY == $past(opc[ioc_pkg::OPC_READY]));
	endproperty
	a_ready: assert property (p_ready) else $error("ready mode mismatch");

	property p_rx_off;
		@(posedge I_REF_CLK) disable iff (!I_RST_B)
		(I_CE && !opc[ioc_pkg::OPC_RX_EN]) |=> (!O_RX_AM_EN && !O_RX_PM_EN && !O_RX_EN);
	endproperty
	a_rx_off: assert property (p_rx_off) else $error("receiver active while off");

	property p_rx_single;
		@(posedge I_REF_CLK) disable iff (!I_RST_B)
		(I_CE && opc[ioc_pkg::OPC_RX_EN] && opc[ioc_pkg::OPC_RX_SINGLE])
			|=> ((O_RX_AM_EN != O_RX_PM_EN) && (O_RX_PM_EN == $past(I_CHANNEL_PICK)));
	endproperty
	a_rx_single: assert property (p_rx_single) else $error("single channel wrong");

	property p_rx_auto;
		@(posedge I_REF_CLK) disable iff (!I_RST_B)
		(I_CE && opc[ioc_pkg::OPC_RX_EN] && !opc[ioc_pkg::OPC_RX_SINGLE])
			|=> (O_RX_AUTO_SELECT == !$past(opc[ioc_pkg::OPC_RX_MANUAL]));
	endproperty
	a_rx_auto: assert property (p_rx_auto) else $error("channel method wrong");

	property p_wakeup;
		@(posedge I_REF_CLK) disable iff (!I_RST_B)
		I_CE |=> (O_WAKEUP_MODE_ENABLE == $past(opc[ioc_pkg::OPC_WAKEUP]));
	endproperty
	a_wakeup: assert property (p_wakeup) else $error("wake-up mismatch");

	property p_fd;
		@(posedge I_REF_CLK) disable iff (!I_RST_B)
		I_CE |=> ((O_FD_ENABLE == ($past(fd) != 2'h0)) && (O_FD_AUTO == ($past(fd) == 2'h3))
			&& (O_FD_PEER_THRESHOLD == ($past(fd) == 2'h2)));
	endproperty
	a_fd: assert property (p_fd) else $error("field detector decode wrong");

	property p_low_power;
		@(posedge I_REF_CLK) disable iff (!I_RST_B)
		(I_CE && fd != 2'h0 && opc[7:2] == 6'h00) |=> O_LOW_POWER_NFC;
	endproperty
	a_low_power: assert property (p_low_power) else $error("low power mode missed");

endmodule

//--- verilog/ioc_pkg.sv
// package: register map, field positions and state types of the io and operation control bank
package ioc_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] IO_CONFIG_SECOND_OFS        = 8'h01;
	localparam logic [7:0] OPERATING_STATE_CONTROL_OFS = 8'h02;
	localparam logic [7:0] IO_CONFIG_SECOND_RST        = 8'h00;
	localparam logic [7:0] OPERATING_STATE_CONTROL_RST = 8'h00;
	localparam logic [7:0] UNMAPPED_READ               = 8'h00;

	// ----------------------------------------------------------------
	// io_config_second fields
	// ----------------------------------------------------------------
	localparam int IO2_SUPPLY_3V     = 7;
	localparam int IO2_DIG_REG_OFF   = 6;
	localparam int IO2_TUNE_DAC_EN   = 5;
	localparam int IO2_PD_IDLE_SEL   = 4;
	localparam int IO2_PD_DESEL      = 3;
	localparam int IO2_DRIVE_HIGH    = 2;
	localparam int IO2_AM_REF_SELECT = 1;
	localparam int IO2_AM_SINK       = 0;

	// ----------------------------------------------------------------
	// operating_state_control fields
	// ----------------------------------------------------------------
	localparam int OPC_READY     = 7;
	localparam int OPC_RX_EN     = 6;
	localparam int OPC_RX_SINGLE = 5;
	localparam int OPC_RX_MANUAL = 4;
	localparam int OPC_TX_EN     = 3;
	localparam int OPC_WAKEUP    = 2;
	localparam int OPC_FD_HI     = 1;
	localparam int OPC_FD_LO     = 0;

	localparam logic [1:0] FD_OFF       = 2'h0;
	localparam logic [1:0] FD_MAN_COLL  = 2'h1;
	localparam logic [1:0] FD_MAN_PEER  = 2'h2;
	localparam logic [1:0] FD_AUTO      = 2'h3;

	typedef struct packed {
		logic [7:0] io_cfg2;
		logic [7:0] op_ctl;
		logic [7:0] rdata;
	} ioc_bank_t;

	typedef struct packed {
		logic s1;
		logic s2;
	} ioc_sync_t;

	function automatic logic [7:0] ioc_read_mux(input logic [7:0] addr,
		input logic [7:0] io2, input logic [7:0] opc);
		logic [7:0] d;
		d = UNMAPPED_READ;
		if (addr == IO_CONFIG_SECOND_OFS)
			d = io2;
		else if (addr == OPERATING_STATE_CONTROL_OFS)
			d = opc;
		return d;
	endfunction

	function automatic logic ioc_low_power(input logic [7:0] opc);
		return (opc[OPC_FD_HI:OPC_FD_LO] != FD_OFF) && (opc[7:2] == 6'h00);
	endfunction

endpackage

//--- verilog/ioc_reg_if.sv
// interface: register contents and transmit enable events between bank and control logic
`timescale 1ns/1ps
interface ioc_reg_if;
	logic [7:0] io_cfg2;
	logic [7:0] op_ctl;
	logic       tx_set;
	logic       tx_clr;

	modport bank
	(
		output io_cfg2,
		output op_ctl,
		input  tx_set,
		input  tx_clr
	);

	modport user
	(
		input  io_cfg2,
		input  op_ctl,
		output tx_set,
		output tx_clr
	);
endinterface

//--- verilog/ioc_sync2.sv
// module: two flip-flop synchroniser for a pin input
`timescale 1ns/1ps
module ioc_sync2
(
	input  wire logic i_clk,
	input  wire logic i_rst_b,
	input  wire logic i_ce,
	input  wire logic i_async,
	output logic      o_sync
);
	ioc_pkg::ioc_sync_t st_r;
	ioc_pkg::ioc_sync_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		if (i_ce)
		begin
			st_nxt.s1 = i_async;
			st_nxt.s2 = st_r.s1;
		end
	end

	// idle value high: chip select deselected
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			st_r <= '{s1: 1'b1, s2: 1'b1};
		else
			st_r <= st_nxt;
	end

	assign o_sync = st_r.s2;
endmodule

//--- verilog/ioc_bank.sv
// module: register storage, host port decode and automatic transmit enable update
`timescale 1ns/1ps
module ioc_bank
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_ce,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	ioc_reg_if.bank         rif
);
	ioc_pkg::ioc_bank_t st_r;
	ioc_pkg::ioc_bank_t st_nxt;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		if (i_ce)
		begin
			st_nxt.rdata = ioc_pkg::UNMAPPED_READ;
			if (i_rd)
				st_nxt.rdata = ioc_pkg::ioc_read_mux(i_addr, st_r.io_cfg2, st_r.op_ctl);
			if (i_wr && i_addr == ioc_pkg::IO_CONFIG_SECOND_OFS)
				st_nxt.io_cfg2 = i_wdata;
			if (i_wr && i_addr == ioc_pkg::OPERATING_STATE_CONTROL_OFS)
				st_nxt.op_ctl = i_wdata;
			// hardware set is applied last so it wins over any clear
			if (rif.tx_clr)
				st_nxt.op_ctl[ioc_pkg::OPC_TX_EN] = 1'b0;
			if (rif.tx_set)
				st_nxt.op_ctl[ioc_pkg::OPC_TX_EN] = 1'b1;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			st_r <= '{io_cfg2: ioc_pkg::IO_CONFIG_SECOND_RST,
				op_ctl: ioc_pkg::OPERATING_STATE_CONTROL_RST, rdata: 8'h00};
		else
			st_r <= st_nxt;
	end

	assign rif.io_cfg2 = st_r.io_cfg2;
	assign rif.op_ctl  = st_r.op_ctl;
	assign o_rdata     = st_r.rdata;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_tx_set;
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_ce && rif.tx_set) |=> rif.op_ctl[ioc_pkg::OPC_TX_EN];
	endproperty
	a_tx_set: assert property (p_tx_set) else $error("transmit enable not set");

	property p_tx_clr;
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_ce && rif.tx_clr && !rif.tx_set) |=> !rif.op_ctl[ioc_pkg::OPC_TX_EN];
	endproperty
	a_tx_clr: assert property (p_tx_clr) else $error("transmit enable not cleared");
endmodule

//--- test/ioc_top_tb.sv
// testbench: self-checking run of the io and operation control bank
`timescale 1ns/1ps
module ioc_top_tb;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic       ref_clk;
	logic       rst_b;
	logic       ce;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       field_on;
	logic       tx_done;
	logic       peer_link;
	logic       pick;
	logic       spi_mode;
	logic       cs_n;
	logic       miso_drv;
	logic       supply_3v;
	logic       dig_off;
	logic       tune_run;
	logic       tune_hold;
	logic       tune_valid;
	logic       miso_pd;
	logic       drive_high;
	logic       am_ref;
	logic       am_sink;
	logic       ready;
	logic       rx_en;
	logic       rx_am;
	logic       rx_pm;
	logic       rx_auto;
	logic       tx_en;
	logic       wake;
	logic       fd_en;
	logic       fd_peer;
	logic       fd_auto;
	logic       low_power;
	int         mismatches;
	int         num_checks;
	int         cycles;

	ioc_top i_ioc_top
	(
		.I_REF_CLK                 (ref_clk),
		.I_RST_B                   (rst_b),
		.I_CE                      (ce),
		.I_ADDR                    (addr),
		.I_WDATA                   (wdata),
		.I_WR                      (wr),
		.I_RD                      (rd),
		.O_RDATA                   (rdata),
		.I_FIELD_ON_CMD            (field_on),
		.I_TX_DONE                 (tx_done),
		.I_ACTIVE_PEER_LINK        (peer_link),
		.I_CHANNEL_PICK            (pick),
		.I_SPI_MODE                (spi_mode),
		.I_CHIP_SELECT_N           (cs_n),
		.I_MISO_DRIVEN             (miso_drv),
		.O_SUPPLY_3V               (supply_3v),
		.O_DIG_REG_OFF             (dig_off),
		.O_TUNE_DAC_RUN            (tune_run),
		.O_TUNE_HOLD_FIXED         (tune_hold),
		.O_TUNE_FIXED_VALID        (tune_valid),
		.O_MISO_PULLDOWN           (miso_pd),
		.O_IO_DRIVE_HIGH           (drive_high),
		.O_AM_REGULATOR_REF_SELECT (am_ref),
		.O_AM_ACTIVE_SINK          (am_sink),
		.O_READY                   (ready),
		.O_RX_EN                   (rx_en),
		.O_RX_AM_EN                (rx_am),
		.O_RX_PM_EN                (rx_pm),
		.O_RX_AUTO_SELECT          (rx_auto),
		.O_TX_EN                   (tx_en),
		.O_WAKEUP_MODE_ENABLE      (wake),
		.O_FD_ENABLE               (fd_en),
		.O_FD_PEER_THRESHOLD       (fd_peer),
		.O_FD_AUTO                 (fd_auto),
		.O_LOW_POWER_NFC           (low_power)
	);

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
		num_checks++;
		if (seen !== exp)
		begin
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
			mismatches++;
		end
	endtask

	// outputs are settled one cycle after the register edge
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask

	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		chk("read data", exp, rdata);
		@(posedge ref_clk);
		#1;
		chk("read data after", 8'h00, rdata);
	endtask

	// chip select passes two sync flops before the output flop
	task automatic pd_case(input logic c, input logic s, input logic m, input logic exp);
		@(posedge ref_clk);
		cs_n     <= c;
		spi_mode <= s;
		miso_drv <= m;
		repeat (3) @(posedge ref_clk);
		#1;
		chk("miso pulldown", {7'h00, exp}, {7'h00, miso_pd});
	endtask

	task automatic op_case(input logic p, input logic [7:0] d, input logic [7:0] exp);
		@(posedge ref_clk);
		pick <= p;
		wr_reg(ioc_pkg::OPERATING_STATE_CONTROL_OFS, d);
		chk("op outputs", exp, {ready, rx_en, rx_am, rx_pm, rx_auto, wake, tx_en, low_power});
		rd_reg(ioc_pkg::OPERATING_STATE_CONTROL_OFS, d);
	endtask

	task automatic pulse_ev(input logic fo, input logic td);
		@(posedge ref_clk);
		field_on <= fo;
		tx_done  <= td;
		@(posedge ref_clk);
		field_on <= 1'b0;
		tx_done  <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		logic [7:0] o;
		rd_reg(ioc_pkg::IO_CONFIG_SECOND_OFS, 8'h00);
		rd_reg(ioc_pkg::OPERATING_STATE_CONTROL_OFS, 8'h00);
		wr_reg(8'h07, 8'hff);
		rd_reg(8'h07, 8'h00);
		rd_reg(ioc_pkg::IO_CONFIG_SECOND_OFS, 8'h00);
		o = {ready, rx_en, tx_en, wake, fd_en, low_power, tune_hold, dig_off};
		chk("idle outputs", 8'h00, o);
	endtask

	task automatic t_io2();
		logic [7:0] d;
		logic [7:0] o;
		for (int i = 0; i < 8; i++)
		begin
			d = 8'h01 << i;
			wr_reg(ioc_pkg::IO_CONFIG_SECOND_OFS, d);
			o = {tune_run, supply_3v, dig_off, tune_hold, miso_pd, drive_high, am_ref, am_sink};
			chk("io2 outputs", {1'b0, d[7:5], d[3:0]}, o);
			rd_reg(ioc_pkg::IO_CONFIG_SECOND_OFS, d);
		end
	endtask

	task automatic t_tune();
		wr_reg(ioc_pkg::IO_CONFIG_SECOND_OFS, 8'h20);
		wr_reg(ioc_pkg::OPERATING_STATE_CONTROL_OFS, 8'h00);
		chk("tuning before ready", 8'h02, {5'h00, tune_run, tune_hold, tune_valid});
		wr_reg(ioc_pkg::OPERATING_STATE_CONTROL_OFS, 8'h80);
		chk("tuning with ready", 8'h04, {5'h00, tune_run, tune_hold, tune_valid});
		wr_reg(ioc_pkg::OPERATING_STATE_CONTROL_OFS, 8'h00);
		chk("tuning after ready", 8'h03, {5'h00, tune_run, tune_hold, tune_valid});
		wr_reg(ioc_pkg::IO_CONFIG_SECOND_OFS, 8'h00);
		chk("tuning off", 8'h00, {5'h00, tune_run, tune_hold, tune_valid});
	endtask

	task automatic t_pulldown();
		wr_reg(ioc_pkg::IO_CONFIG_SECOND_OFS, 8'h10);
		pd_case(1'b0, 1'b1, 1'b0, 1'b1);
		pd_case(1'b0, 1'b1, 1'b1, 1'b0);
		pd_case(1'b0, 1'b0, 1'b0, 1'b0);
		pd_case(1'b1, 1'b1, 1'b0, 1'b0);
		wr_reg(ioc_pkg::IO_CONFIG_SECOND_OFS, 8'h08);
		pd_case(1'b1, 1'b0, 1'b1, 1'b1);
		pd_case(1'b0, 1'b1, 1'b0, 1'b0);
		wr_reg(ioc_pkg::IO_CONFIG_SECOND_OFS, 8'h00);
	endtask

	task automatic t_opctl();
		logic [1:0] f;
		logic [7:0] o;
		logic [7:0] x;
		op_case(1'b0, 8'h80, 8'h80);
		op_case(1'b0, 8'h40, 8'h78);
		op_case(1'b0, 8'h60, 8'h60);
		op_case(1'b1, 8'h60, 8'h50);
		op_case(1'b1, 8'h50, 8'h70);
		op_case(1'b0, 8'h20, 8'h00);
		op_case(1'b0, 8'h04, 8'h04);
		op_case(1'b0, 8'h08, 8'h02);
		for (int i = 0; i < 4; i++)
		begin
			f = 2'(i);
			wr_reg(ioc_pkg::OPERATING_STATE_CONTROL_OFS, {6'h00, f});
			x = {4'h0, f != 2'h0, f == 2'h2, f == 2'h3, f != 2'h0};
			o = {4'h0, fd_en, fd_peer, fd_auto, low_power};
			chk("detector mode", x, o);
		end
		wr_reg(ioc_pkg::OPERATING_STATE_CONTROL_OFS, 8'h83);
		chk("detector with ready", 8'h0a, {4'h0, fd_en, fd_peer, fd_auto, low_power});
	endtask

	task automatic t_tx();
		// reader mode: collision threshold while field-on commands are issued
		wr_reg(ioc_pkg::OPERATING_STATE_CONTROL_OFS, 8'h01);
		pulse_ev(1'b1, 1'b0);
		chk("tx after field on", 8'h01, {7'h00, tx_en});
		rd_reg(ioc_pkg::OPERATING_STATE_CONTROL_OFS, 8'h09);
		pulse_ev(1'b0, 1'b1);
		chk("tx done outside peer link", 8'h01, {7'h00, tx_en});
		// active link: automatic detector setting
		wr_reg(ioc_pkg::OPERATING_STATE_CONTROL_OFS, 8'h0b);
		@(posedge ref_clk);
		peer_link <= 1'b1;
		pulse_ev(1'b0, 1'b1);
		chk("tx done in peer link", 8'h00, {7'h00, tx_en});
		rd_reg(ioc_pkg::OPERATING_STATE_CONTROL_OFS, 8'h03);
		// field-on beats a software clear in the same cycle
		@(posedge ref_clk);
		wr       <= 1'b1;
		addr     <= ioc_pkg::OPERATING_STATE_CONTROL_OFS;
		wdata    <= 8'h03;
		field_on <= 1'b1;
		@(posedge ref_clk);
		wr        <= 1'b0;
		field_on  <= 1'b0;
		peer_link <= 1'b0;
		rd_reg(ioc_pkg::OPERATING_STATE_CONTROL_OFS, 8'h0b);
	endtask

	task automatic t_ce();
		wr_reg(ioc_pkg::IO_CONFIG_SECOND_OFS, 8'h05);
		chk("drive and sink", 8'h03, {6'h00, drive_high, am_sink});
		@(posedge ref_clk);
		ce <= 1'b0;
		wr_reg(ioc_pkg::IO_CONFIG_SECOND_OFS, 8'hff);
		chk("frozen outputs", 8'h03, {5'h00, dig_off, drive_high, am_sink});
		@(posedge ref_clk);
		ce <= 1'b1;
		rd_reg(ioc_pkg::IO_CONFIG_SECOND_OFS, 8'h05);
	endtask

	// ----------------------------------------------------------------
	// clock, timeout and main sequence
	// ----------------------------------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			mismatches++;
			stop_test();
		end
	end

	initial
	begin
		mismatches = 0;
		num_checks = 0;
		cycles     = 0;
		rst_b      = 1'b0;
		ce         = 1'b1;
		addr       = 8'h00;
		wdata      = 8'h00;
		wr         = 1'b0;
		rd         = 1'b0;
		field_on   = 1'b0;
		tx_done    = 1'b0;
		peer_link  = 1'b0;
		pick       = 1'b0;
		spi_mode   = 1'b0;
		cs_n       = 1'b1;
		miso_drv   = 1'b0;
		repeat (6) @(posedge ref_clk);
		rst_b <= 1'b1;
		t_reset();
		t_io2();
		t_tune();
		t_pulldown();
		t_opctl();
		t_tx();
		t_ce();
		stop_test();
	end
endmodule
